// ### uab_map.svh
// Constants for the autobaud, escape detect and infrared helper block.
// Assumes a 40 MHz system clock and a plain strobe register port.
`ifndef UAB_MAP_SVH
`define UAB_MAP_SVH
`define UAB_A_CTRL 4'h0
`define UAB_A_STAT 4'h1
`define UAB_A_COUNT 4'h2
`define UAB_A_ESCCH 4'h3
`define UAB_A_ESCTIM 4'h4
`define UAB_A_RXDATA 4'h5
`define UAB_A_INC 4'h6
`define UAB_A_MOD 4'h7
`define UAB_B_ABEN 0
`define UAB_B_ABIE 1
`define UAB_B_ESCIE 2
`define UAB_B_INFRARED_ENABLE 3
`define UAB_B_INV 4
`define UAB_B_IRIE 5
`define UAB_B_R16 6
`define UAB_B_R25 7
`define UAB_B_R30 8
`define UAB_S_DONE 0
`define UAB_S_ESC 1
`define UAB_S_IRE 2
`define UAB_S_RDY 3
`define UAB_CNT_RST 16'h0008
`define UAB_CNT_MAX 16'hFFFF
`define UAB_CH_UA 8'h41
`define UAB_CH_LA 8'h61
`define UAB_OVS 16
`define UAB_IR_PULSE 3
`define UAB_TICK_NS 2000000
`define UAB_R16_HZ 16000000
`define UAB_R25_HZ 25000000
`define UAB_R30_HZ 30000000
`define UAB_TICK_DIV 500
`define UAB_ESC_RST 8'h2B
`define UAB_INC_RST 16'h000F
`define UAB_ESC_NEED 2'h3
`endif

// ### uab_pkg.sv
// Types for the autobaud, escape detect and infrared helper block.
// Used with uab_map.svh, which holds the numbers.
package uab_pkg;
    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } uab_bus_t;
    typedef struct packed {
        logic [7:0] data;
        logic err;
        logic valid;
    } uab_char_t;
    typedef enum logic [1:0] {
        UAB_IDLE = 2'b00,
        UAB_MEAS = 2'b01,
        UAB_HOLD = 2'b10
    } uab_ab_t;
endpackage

// ### uab_tick.sv
// Integer tick generator: one-cycle pulse every period cycles of the clock.
// Assumes the clock rate is given in Hz and the period in clock cycles.
`timescale 1ns/1ps
module uab_tick_gen #(
    parameter int CLK_HZ = 40000000,
    parameter int W = 32
)(
    input wire logic clk, // System clock
    input wire logic rst, // Async reset, active high
    input wire logic [W-1:0] period, // Cycles per tick, at least 1
    output logic tick // One-cycle enable
);
    logic [W-1:0] cnt_r;
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cnt_r <= '0;
            tick <= 1'b0;
        end
        else if (cnt_r + 1'b1 >= period)
        begin
            cnt_r <= '0;
            tick <= 1'b1;
        end
        else
        begin
            cnt_r <= cnt_r + 1'b1;
            tick <= 1'b0;
        end
    end
endmodule

// ### uab_core.sv
// Autobaud measurement, escape sequence detect and infrared encode/decode.
// Assumes a receiver delivers characters and raw tx bits with a 16x enable.
//
// The register offsets and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`include "uab_map.svh"
module uab_core import uab_pkg::*; #(
    parameter int CLK_HZ = 40000000,
    parameter int CW = 16,
    parameter int ESC_TICK_CYC = (CLK_HZ / 1000) * 2
)(
    input wire logic clk, // System clock
    input wire logic rst, // Async reset
    input wire uab_bus_t bus, // Register strobes
    output logic [15:0] rdata, // Read data, cycle after strobe
    input wire logic rxPin, // Receive pin
    input wire uab_char_t rxChar, // Received character from receiver
    input wire logic txBit, // Serial tx bit from transmitter
    input wire logic ovsEn, // 16x bit-rate enable
    output logic txPin, // Transmit pin
    output logic irRxBit, // Decoded infrared bit to receiver
    output logic rawRxBit, // Plain rx to receiver
    output logic combined_irq_n, // Combined interrupt, active low
    output logic [15:0] divider_increment, // Divider value in use
    output logic [15:0] divider_modulator // Modulator value in use
);
    logic autobaud_enable_r;
    logic autobaud_irq_enable_r;
    logic escape_irq_enable_r;
    logic infrared_enable_r;
    logic rx_invert_r;
    logic infrared_edge_irq_enable_r;
    logic [2:0] refSel_r;
    logic autobaud_done_flag_r;
    logic escape_seen_flag_r;
    logic infrared_edge_flag_r;
    logic rxReady_r;
    logic [7:0] rxHold_r;
    logic [CW-1:0] start_bit_length_count_r;
    logic [7:0] escape_char_value_r;
    logic [11:0] escape_interval_limit_r;
    logic [15:0] incSw_r;
    logic [15:0] modSw_r;
    uab_ab_t abState_r;
    logic rxPrev_r;
    logic pinPrev_r;
    logic wrCtrl;
    logic wrStat;
    logic abDetect;
    logic isA;
    logic escTick;
    logic [31:0] tickPeriod;
    logic [11:0] escTime_r;
    logic escRun_r;
    logic [1:0] escCount_r;
    logic [3:0] irPh_r;
    logic [3:0] irLow_r;

    assign wrCtrl = bus.wr && bus.addr == `UAB_A_CTRL;
    assign wrStat = bus.wr && bus.addr == `UAB_A_STAT;
    assign abDetect = autobaud_enable_r && !autobaud_done_flag_r;
    assign isA = rxChar.data == `UAB_CH_UA || rxChar.data == `UAB_CH_LA;

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            autobaud_enable_r <= 1'b0;
            autobaud_irq_enable_r <= 1'b0;
            escape_irq_enable_r <= 1'b0;
            infrared_enable_r <= 1'b0;
            rx_invert_r <= 1'b0;
            infrared_edge_irq_enable_r <= 1'b0;
            refSel_r <= 3'h0;
            escape_char_value_r <= `UAB_ESC_RST;
            escape_interval_limit_r <= 12'h000;
            incSw_r <= `UAB_INC_RST;
            modSw_r <= 16'h0000;
        end
        else if (bus.wr)
        begin
            if (bus.addr == `UAB_A_CTRL)
            begin
                autobaud_enable_r <= bus.wdata[`UAB_B_ABEN];
                autobaud_irq_enable_r <= bus.wdata[`UAB_B_ABIE];
                escape_irq_enable_r <= bus.wdata[`UAB_B_ESCIE];
                infrared_enable_r <= bus.wdata[`UAB_B_INFRARED_ENABLE];
                rx_invert_r <= bus.wdata[`UAB_B_INV];
                infrared_edge_irq_enable_r <= bus.wdata[`UAB_B_IRIE];
                refSel_r <= bus.wdata[`UAB_B_R30:`UAB_B_R16];
            end
            else if (bus.addr == `UAB_A_ESCCH)
                escape_char_value_r <= bus.wdata[7:0];
            else if (bus.addr == `UAB_A_ESCTIM)
                escape_interval_limit_r <= bus.wdata[11:0];
            else if (bus.addr == `UAB_A_INC)
                incSw_r <= bus.wdata;
            else if (bus.addr == `UAB_A_MOD)
                modSw_r <= bus.wdata;
        end
    end

    // ------------------------------------------------------------
    // Start-bit measurement
    // ------------------------------------------------------------
    // Measurement restarts at the first falling edge after each received character while armed, so a bad
    // character just gets overwritten by the next attempt.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            abState_r <= UAB_IDLE;
            start_bit_length_count_r <= `UAB_CNT_RST;
            rxPrev_r <= 1'b1;
        end
        else
        begin
            rxPrev_r <= rawRxBit;
            case (abState_r)
                UAB_IDLE:
                begin
                    if (abDetect && rxPrev_r && !rawRxBit)
                    begin
                        abState_r <= UAB_MEAS;
                        start_bit_length_count_r <= CW'(1);
                    end
                end
                UAB_MEAS:
                begin
                    if (!abDetect)
                        abState_r <= UAB_IDLE;
                    else if (rawRxBit)
                        abState_r <= UAB_HOLD;
                    else if (start_bit_length_count_r != `UAB_CNT_MAX)
                        start_bit_length_count_r <= start_bit_length_count_r + 1'b1;
                end
                UAB_HOLD:
                begin
                    if (!abDetect || (rxChar.valid && !autobaud_done_flag_r))
                        abState_r <= UAB_IDLE;
                end
                default:
                    abState_r <= UAB_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Status flags, set wins over write-one clear
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            autobaud_done_flag_r <= 1'b0;
        else if (abDetect && abState_r == UAB_HOLD && rxChar.valid && !rxChar.err && isA)
            autobaud_done_flag_r <= 1'b1;
        else if (wrStat && bus.wdata[`UAB_S_DONE])
            autobaud_done_flag_r <= 1'b0;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            escape_seen_flag_r <= 1'b0;
        else if (escape_irq_enable_r && rxChar.valid && !rxChar.err
                 && rxChar.data == escape_char_value_r && escCount_r == 2'h2
                 && (escRun_r || 1'b0))
            escape_seen_flag_r <= 1'b1;
        else if (wrStat && bus.wdata[`UAB_S_ESC])
            escape_seen_flag_r <= 1'b0;
    end

    // Edges come from the pin itself: the plain receive path is held high in infrared mode
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            infrared_edge_flag_r <= 1'b0;
            pinPrev_r <= 1'b1;
        end
        else
        begin
            pinPrev_r <= rxPin;
            if (infrared_enable_r && (rx_invert_r ? (!pinPrev_r && rxPin)
                                                  : (pinPrev_r && !rxPin)))
                infrared_edge_flag_r <= 1'b1;
            else if (wrStat && bus.wdata[`UAB_S_IRE])
                infrared_edge_flag_r <= 1'b0;
        end
    end

    // Holds the last character so software can read back the 'A'
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rxReady_r <= 1'b0;
            rxHold_r <= 8'h00;
        end
        else if (rxChar.valid)
        begin
            rxReady_r <= 1'b1;
            rxHold_r <= rxChar.data;
        end
        else if (bus.rd && bus.addr == `UAB_A_RXDATA)
            rxReady_r <= 1'b0;
    end

    // ------------------------------------------------------------
    // Divider values and interrupt
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            divider_increment <= 16'h0000;
            divider_modulator <= 16'h0000;
            combined_irq_n <= 1'b1;
        end
        else
        begin
            if (abDetect)
            begin
                divider_increment <= 16'h0000;
                divider_modulator <= 16'h0000;
            end
            else if (autobaud_done_flag_r)
            begin
                divider_increment <= 16'h0000;
                divider_modulator <= 16'(start_bit_length_count_r / `UAB_OVS);
            end
            else
            begin
                divider_increment <= incSw_r;
                divider_modulator <= modSw_r;
            end
            combined_irq_n <= !((autobaud_done_flag_r && autobaud_enable_r
                                 && autobaud_irq_enable_r)
                                || (infrared_edge_flag_r && infrared_edge_irq_enable_r)
                                || escape_seen_flag_r);
        end
    end

    // ------------------------------------------------------------
    // Escape timer
    // ------------------------------------------------------------
    always_comb
    begin
        tickPeriod = 32'(ESC_TICK_CYC);
        // The block runs on the reference clock, so a selected reference fixes the count
        if (refSel_r[0])
            tickPeriod = 32'(`UAB_R16_HZ / `UAB_TICK_DIV);
        else if (refSel_r[1])
            tickPeriod = 32'(`UAB_R25_HZ / `UAB_TICK_DIV);
        else if (refSel_r[2])
            tickPeriod = 32'(`UAB_R30_HZ / `UAB_TICK_DIV);
    end

    uab_tick_gen #(.CLK_HZ(CLK_HZ), .W(32)) tickGen (
        .clk(clk),
        .rst(rst),
        .period(tickPeriod),
        .tick(escTick)
    );

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            escRun_r <= 1'b0;
            escTime_r <= 12'h000;
            escCount_r <= 2'h0;
        end
        else if (rxChar.valid && !rxChar.err && rxChar.data == escape_char_value_r)
        begin
            escRun_r <= 1'b1;
            escTime_r <= 12'h000;
            if (!escRun_r || escCount_r == 2'h2)
                escCount_r <= 2'h1;
            else
                escCount_r <= escCount_r + 2'h1;
        end
        else if (rxChar.valid)
        begin
            escRun_r <= 1'b0;
            escCount_r <= 2'h0;
        end
        else if (escRun_r && escTick)
        begin
            if (escTime_r == escape_interval_limit_r)
            begin
                escRun_r <= 1'b0;
                escCount_r <= 2'h0;
            end
            else
                escTime_r <= escTime_r + 12'h001;
        end
    end

    // ------------------------------------------------------------
    // Infrared encode and decode
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            irPh_r <= 4'h0;
            txPin <= 1'b1;
        end
        else
        begin
            if (ovsEn)
                irPh_r <= irPh_r + 4'h1;
            if (infrared_enable_r)
                txPin <= !txBit && irPh_r < 4'(`UAB_IR_PULSE);
            else
                txPin <= txBit;
        end
    end

    // A low pulse keeps the decoder output at zero until 15 enables after the pin goes back high
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            irLow_r <= 4'h0;
            irRxBit <= 1'b1;
            rawRxBit <= 1'b1;
        end
        else
        begin
            rawRxBit <= infrared_enable_r ? 1'b1 : (rxPin ^ rx_invert_r);
            if (infrared_enable_r && (rxPin ^ rx_invert_r) == 1'b0)
                irLow_r <= 4'hF;
            else if (ovsEn && irLow_r != 4'h0)
                irLow_r <= irLow_r - 4'h1;
            irRxBit <= !(infrared_enable_r && irLow_r != 4'h0);
        end
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            rdata <= 16'h0000;
        else if (!bus.rd)
            rdata <= 16'h0000;
        else if (bus.addr == `UAB_A_CTRL)
            rdata <= {7'h00, refSel_r, infrared_edge_irq_enable_r, rx_invert_r,
                      infrared_enable_r, escape_irq_enable_r, autobaud_irq_enable_r,
                      autobaud_enable_r};
        else if (bus.addr == `UAB_A_STAT)
            rdata <= {12'h000, rxReady_r, infrared_edge_flag_r, escape_seen_flag_r,
                      autobaud_done_flag_r};
        else if (bus.addr == `UAB_A_COUNT)
            rdata <= 16'(start_bit_length_count_r);
        else if (bus.addr == `UAB_A_ESCCH)
            rdata <= {8'h00, escape_char_value_r};
        else if (bus.addr == `UAB_A_ESCTIM)
            rdata <= {4'h0, escape_interval_limit_r};
        else if (bus.addr == `UAB_A_RXDATA)
            rdata <= {8'h00, rxHold_r};
        else if (bus.addr == `UAB_A_INC)
            rdata <= incSw_r;
        else if (bus.addr == `UAB_A_MOD)
            rdata <= modSw_r;
        else
            rdata <= 16'h0000;
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    count_saturates_a: assert property (@(posedge clk) disable iff (rst)
        start_bit_length_count_r == `UAB_CNT_MAX && abState_r == UAB_MEAS
        |=> start_bit_length_count_r == `UAB_CNT_MAX)
        else $error("start-bit counter wrapped");
    count_frozen_a: assert property (@(posedge clk) disable iff (rst)
        !autobaud_enable_r |=> $stable(start_bit_length_count_r))
        else $error("counter moved while disabled");
    done_cause_a: assert property (@(posedge clk) disable iff (rst)
        $rose(autobaud_done_flag_r) |-> $past(rxChar.valid) && !$past(rxChar.err))
        else $error("done set without good character");
    irq_hold_a: assert property (@(posedge clk) disable iff (rst)
        autobaud_done_flag_r && autobaud_enable_r && autobaud_irq_enable_r
        |=> !combined_irq_n)
        else $error("autobaud interrupt missing");
    div_forced_a: assert property (@(posedge clk) disable iff (rst)
        abDetect |=> divider_increment == 16'h0000 && divider_modulator == 16'h0000)
        else $error("divider not forced to zero");
    tx_idle_a: assert property (@(posedge clk) disable iff (rst)
        infrared_enable_r && txBit |=> !txPin)
        else $error("infrared pulse on a one bit");
    ir_edge_a: assert property (@(posedge clk) disable iff (rst)
        infrared_enable_r && !rx_invert_r && pinPrev_r && !rxPin
        |=> infrared_edge_flag_r)
        else $error("edge flag not set");
    ready_clear_a: assert property (@(posedge clk) disable iff (rst)
        bus.rd && bus.addr == `UAB_A_RXDATA && !rxChar.valid |=> !rxReady_r)
        else $error("ready not cleared by read");
endmodule

// ### uab_remote.sv
// Remote serial sender model: drives the receive pin and the character strobe.
// Assumes one caller at a time; the line idles high.
`timescale 1ns/1ps
module uab_remote import uab_pkg::*;
(
    input wire logic clk, // System clock
    output logic rxPin, // Line toward the block
    output uab_char_t rxChar // Character strobe
);
    initial
    begin
        rxPin = 1'b1;
        rxChar = '0;
    end
    // Data shown only while valid; inverted afterwards so stale values never match
    task automatic pulseChar(input logic [7:0] ch, input logic bad);
        @(posedge clk);
        rxChar <= '{data: ch, err: bad, valid: 1'b1};
        @(posedge clk);
        rxChar <= '{data: ~ch, err: ~bad, valid: 1'b0};
    endtask
    task automatic sendChar(input int len, input logic [7:0] ch, input logic bad);
        @(posedge clk);
        rxPin <= 1'b0;
        repeat (len) @(posedge clk);
        rxPin <= 1'b1;
        repeat (4) @(posedge clk);
        pulseChar(ch, bad);
    endtask
    task automatic setLine(input logic lvl);
        @(posedge clk);
        rxPin <= lvl;
    endtask
endmodule

// ### testbench.sv
// Self-checking bench for the autobaud, escape and infrared block.
// Assumes a shortened 2 ms tick of 8 cycles (small CLK_HZ, no reference bit).
`timescale 1ns/1ps
`include "uab_map.svh"
module testbench import uab_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    uab_bus_t bus = '0;
    logic [15:0] rdata;
    logic rxPin;
    uab_char_t rxChar;
    logic txBit = 1'b1;
    logic ovsEn = 1'b0;
    logic txPin, irRxBit, rawRxBit, combined_irq_n;
    logic [15:0] divider_increment, divider_modulator;
    logic [15:0] v;
    int errors = 0;
    int checks_done = 0;
    int n;
    always #12.5 clk = ~clk;
    uab_core #(.CLK_HZ(4000)) dut (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata),
        .rxPin(rxPin), .rxChar(rxChar), .txBit(txBit), .ovsEn(ovsEn), .txPin(txPin),
        .irRxBit(irRxBit), .rawRxBit(rawRxBit), .combined_irq_n(combined_irq_n),
        .divider_increment(divider_increment), .divider_modulator(divider_modulator));
    uab_remote rem (.clk(clk), .rxPin(rxPin), .rxChar(rxChar));
    // ----------------------------------------
    // Bus and check tasks
    // ----------------------------------------
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
            errors++;
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus <= '0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus <= '0;
        #1 d = rdata;
    endtask
    task automatic pollStat(input int b, output logic [15:0] d);
        for (int i = 0; i < 8; i++)
        begin
            rd(`UAB_A_STAT, d);
            if (d[b] === 1'b1)
                break;
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        repeat (100000) @(posedge clk);
        errors++;
        tally_and_finish();
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk("irq", {15'h0, combined_irq_n}, 16'h0001);
        chk("tx", {15'h0, txPin}, 16'h0001);
        rd(`UAB_A_COUNT, v);
        chk("count", v, `UAB_CNT_RST);
        rd(4'hF, v);
        chk("unmapped", v, 16'h0000);
        rem.sendChar(50, `UAB_CH_UA, 1'b0);
        rd(`UAB_A_COUNT, v);
        chk("count", v, `UAB_CNT_RST);
        $display("test reset done");
        wr(`UAB_A_CTRL, 16'h0003);
        wr(`UAB_A_STAT, 16'h0001);
        repeat (2) @(posedge clk);
        chk("inc", divider_increment, 16'h0000);
        chk("mod", divider_modulator, 16'h0000);
        rem.sendChar(200, 8'h42, 1'b0);
        rd(`UAB_A_STAT, v);
        chk("done", v & 16'h0001, 16'h0000);
        rem.sendChar(160, `UAB_CH_UA, 1'b1);
        rd(`UAB_A_STAT, v);
        chk("done", v & 16'h0001, 16'h0000);
        rd(`UAB_A_COUNT, v);
        chk("count", v, 16'h00A0);
        rem.sendChar(160, `UAB_CH_LA, 1'b0);
        pollStat(`UAB_S_DONE, v);
        chk("done", v & 16'h0009, 16'h0009);
        chk("irq", {15'h0, combined_irq_n}, 16'h0000);
        chk("mod", divider_modulator, 16'h000A);
        rd(`UAB_A_RXDATA, v);
        chk("rxdata", v & 16'h00FF, 16'h0061);
        rd(`UAB_A_STAT, v);
        chk("ready", v & 16'h0008, 16'h0000);
        rem.sendChar(80, 8'h55, 1'b0);
        rd(`UAB_A_COUNT, v);
        chk("count", v, 16'h00A0);
        wr(`UAB_A_CTRL, 16'h0001);
        repeat (2) @(posedge clk);
        chk("irq", {15'h0, combined_irq_n}, 16'h0001);
        // Re-armed, with a start bit held just past the counter range
        wr(`UAB_A_STAT, 16'h0001);
        rem.sendChar(65600, 8'h00, 1'b1);
        rd(`UAB_A_COUNT, v);
        chk("count", v, `UAB_CNT_MAX);
        $display("test autobaud done");
        wr(`UAB_A_ESCTIM, 16'h0003);
        // Limit 3 gives 32 cycles: gap 6 fits, gap 100 does not
        for (int t = 0; t < 3; t++)
        begin
            wr(`UAB_A_STAT, 16'h0006);
            // The shortened tick stands in for a supported reference
            wr(`UAB_A_CTRL, (t == 2) ? 16'h0001 : 16'h0005);
            for (int k = 0; k < 3; k++)
            begin
                rem.pulseChar(8'h2B, 1'b0);
                repeat ((t == 1) ? 100 : 6) @(posedge clk);
            end
            rd(`UAB_A_STAT, v);
            chk("escape", v & 16'h0002, (t == 0) ? 16'h0002 : 16'h0000);
        end
        wr(`UAB_A_CTRL, 16'h0005);
        for (int k = 0; k < 3; k++)
            rem.pulseChar(8'h2B, 1'b0);
        wr(`UAB_A_STAT, 16'h0000);
        rd(`UAB_A_STAT, v);
        chk("escape", v & 16'h0002, 16'h0002);
        wr(`UAB_A_STAT, 16'h0002);
        rd(`UAB_A_STAT, v);
        chk("escape", v & 16'h0002, 16'h0000);
        $display("test escape done");
        wr(`UAB_A_CTRL, 16'h0008);
        ovsEn <= 1'b1;
        for (int b = 0; b < 2; b++)
        begin
            @(posedge clk);
            txBit <= b[0];
            repeat (4) @(posedge clk);
            n = 0;
            repeat (32) @(negedge clk) n += txPin;
            chk("irpulse", n[15:0], b ? 16'h0000 : 16'h0006);
        end
        wr(`UAB_A_CTRL, 16'h0000);
        txBit <= 1'b0;
        repeat (4) @(negedge clk);
        chk("txplain", {15'h0, txPin}, 16'h0000);
        wr(`UAB_A_STAT, 16'h0004);
        wr(`UAB_A_CTRL, 16'h0028);
        rem.setLine(1'b0);
        repeat (4) @(negedge clk);
        chk("raw", {15'h0, rawRxBit}, 16'h0001);
        chk("irrx", {15'h0, irRxBit}, 16'h0000);
        rd(`UAB_A_STAT, v);
        chk("edge", v & 16'h0004, 16'h0004);
        chk("irq", {15'h0, combined_irq_n}, 16'h0000);
        wr(`UAB_A_STAT, 16'h0000);
        rd(`UAB_A_STAT, v);
        chk("edge", v & 16'h0004, 16'h0004);
        wr(`UAB_A_STAT, 16'h0004);
        wr(`UAB_A_CTRL, 16'h0038);
        rd(`UAB_A_STAT, v);
        chk("edge", v & 16'h0004, 16'h0000);
        rem.setLine(1'b1);
        repeat (4) @(posedge clk);
        rd(`UAB_A_STAT, v);
        chk("edge", v & 16'h0004, 16'h0004);
        $display("test infrared done");
        tally_and_finish();
    end
endmodule
